// [rtl/smmpi_defs.vh]
// constants for the smm pin interface block
// Functional notes
// - compatible mode forces code-access and main-memory-access controls off.
// - compatible mode asserts active output only while inside the service routine.
// - native mode interrupt pin is bidirectional, sampled every rising clock.
// - native mode drives interrupt pin during routine, or soft entry with code-access.
// - native mode strobe marks current bus cycle as smm memory access.
// - compatible mode i/o trap when interrupt sampled three or more clocks before ready.
// - compatible mode active output asserted throughout the service routine.
// - config three bit 3 selects mode, one is compatible, reset zero.
// - once locked, mode and lock writes ignored until hardware reset.
// - both pins stay disabled after reset until software enables them.
`ifndef SMMPI_DEFS_VH
`define SMMPI_DEFS_VH
`define SMMPI_MODE_BIT      3
`define SMMPI_MODE_RST      1'h0
`define SMMPI_LOCK_RST      1'h0
`define SMMPI_EN_RST        1'h0
`define SMMPI_TRAP_CLKS     3'h3
`define SMMPI_CNT_W         3
`define SMMPI_CNT_RST       3'h0
`define SMMPI_CNT_ONE       3'h1
`define SMMPI_PIN_IDLE      1'h1
`define SMMPI_PIN_ACTIVE    1'h0
`define SMMPI_FLAG_RST      1'h0
`endif

// [rtl/smmpi_top.v]
// smm pin interface: mode control, pin drive and i/o trap detection
`timescale 1ns/1ps
`include "smmpi_defs.vh"
module smmpi_top (
	input  wire       clk_i,
	input  wire       reset_i,
	input  wire       cfg3_wr_i,
	input  wire [7:0] cfg3_wdata_i,
	input  wire       cfg_lock_wr_i,
	input  wire       cfg_lock_wdata_i,
	input  wire       pins_en_wr_i,
	input  wire       pins_en_wdata_i,
	input  wire       smm_code_access_ctl_i,
	input  wire       main_mem_access_ctl_i,
	input  wire       in_smi_routine_i,
	input  wire       soft_entry_i,
	input  wire       smm_cycle_i,
	input  wire       io_cycle_i,
	input  wire       ready_n_i,
	input  wire       burst_ready_n_i,
	input  wire       sys_mgmt_irq_n_i,
	output reg        sys_mgmt_irq_n_o,
	output reg        sys_mgmt_irq_n_oe_n_o,
	output reg        smm_addr_strobe_n_o,
	output reg        smm_active_n_o,
	output reg        smm_iface_select_o,
	output reg        smm_cfg_lock_o,
	output reg        pins_en_o,
	output reg        code_access_eff_o,
	output reg        main_mem_eff_o,
	output reg        smi_req_o,
	output reg        io_trap_o,
	output reg        irq_sample_o
);

	////////////////////////////////////////////////////////////////////////
	// interface states, one-hot
	localparam [2:0] ST_IDLE   = 3'b001;
	localparam [2:0] ST_NATIVE = 3'b010;
	localparam [2:0] ST_COMPAT = 3'b100;

	////////////////////////////////////////////////////////////////////////
	// internal state and next values
	reg  [`SMMPI_CNT_W-1:0] asrt_cnt_r;
	reg  [`SMMPI_CNT_W-1:0] asrt_cnt_nxt;
	reg                     irq_prev_r;
	reg  [2:0]              iface_state;
	reg                     select_nxt;
	reg                     lock_nxt;
	reg                     pins_en_nxt;
	reg                     irq_n_nxt;
	reg                     irq_oe_n_nxt;
	reg                     strobe_n_nxt;
	reg                     active_n_nxt;
	reg                     smi_req_nxt;
	reg                     io_trap_nxt;
	reg                     code_eff_nxt;
	reg                     main_mem_nxt;
	reg                     irq_sample_nxt;
	wire                    mode_nxt;
	wire                    mode_wr_ok;
	wire                    lock_wr_ok;
	wire                    irq_low;
	wire                    fall;
	wire                    cycle_end;
	wire                    native_drive;
	wire                    trap_armed;

	////////////////////////////////////////////////////////////////////////
	// decode
	assign mode_nxt     = cfg3_wdata_i[`SMMPI_MODE_BIT];
	assign mode_wr_ok   = cfg3_wr_i & ~smm_cfg_lock_o;
	assign lock_wr_ok   = cfg_lock_wr_i & ~smm_cfg_lock_o;
	assign irq_low      = ~sys_mgmt_irq_n_i;
	assign fall         = irq_prev_r & irq_low;
	assign cycle_end    = io_cycle_i & (~ready_n_i | ~burst_ready_n_i);
	assign native_drive = in_smi_routine_i | (soft_entry_i & smm_code_access_ctl_i);
	assign trap_armed   = (asrt_cnt_r == `SMMPI_TRAP_CLKS);

	always @* begin
		if (!pins_en_o)
			iface_state = ST_IDLE;
		else if (!smm_iface_select_o)
			iface_state = ST_NATIVE;
		else
			iface_state = ST_COMPAT;
	end

	////////////////////////////////////////////////////////////////////////
	// configuration next values
	always @* begin
		select_nxt  = smm_iface_select_o;
		lock_nxt    = smm_cfg_lock_o;
		pins_en_nxt = pins_en_o;
		if (mode_wr_ok)
			select_nxt = mode_nxt;
		if (lock_wr_ok)
			lock_nxt = cfg_lock_wdata_i;
		if (pins_en_wr_i)
			pins_en_nxt = pins_en_wdata_i;
	end

	////////////////////////////////////////////////////////////////////////
	// sampled and gated control next values
	always @* begin
		irq_sample_nxt = pins_en_o & irq_low;
		code_eff_nxt   = smm_code_access_ctl_i & ~smm_iface_select_o;
		main_mem_nxt   = main_mem_access_ctl_i & ~smm_iface_select_o;
	end

	////////////////////////////////////////////////////////////////////////
	// assertion counter, saturating
	always @* begin
		asrt_cnt_nxt = `SMMPI_CNT_RST;
		if (iface_state == ST_COMPAT && irq_low) begin
			if (trap_armed)
				asrt_cnt_nxt = asrt_cnt_r;
			else
				asrt_cnt_nxt = asrt_cnt_r + `SMMPI_CNT_ONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin and event next values
	always @* begin
		irq_n_nxt    = `SMMPI_PIN_IDLE;
		irq_oe_n_nxt = `SMMPI_PIN_IDLE;
		strobe_n_nxt = `SMMPI_PIN_IDLE;
		active_n_nxt = `SMMPI_PIN_IDLE;
		smi_req_nxt  = `SMMPI_FLAG_RST;
		io_trap_nxt  = `SMMPI_FLAG_RST;
		case (iface_state)
			ST_IDLE: begin
				irq_oe_n_nxt = `SMMPI_PIN_IDLE;
				strobe_n_nxt = `SMMPI_PIN_IDLE;
			end
			ST_NATIVE: begin
				irq_n_nxt    = `SMMPI_PIN_ACTIVE;
				irq_oe_n_nxt = ~native_drive;
				strobe_n_nxt = ~smm_cycle_i;
				smi_req_nxt  = irq_low;
			end
			ST_COMPAT: begin
				irq_oe_n_nxt = `SMMPI_PIN_IDLE;
				active_n_nxt = ~in_smi_routine_i;
				smi_req_nxt  = fall;
				io_trap_nxt  = cycle_end & trap_armed;
			end
			default: begin
				irq_oe_n_nxt = `SMMPI_PIN_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			smm_iface_select_o <= `SMMPI_MODE_RST;
		end else begin
			smm_iface_select_o <= select_nxt;
		end
	end

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			smm_cfg_lock_o <= `SMMPI_LOCK_RST;
		end else begin
			smm_cfg_lock_o <= lock_nxt;
		end
	end

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pins_en_o <= `SMMPI_EN_RST;
		end else begin
			pins_en_o <= pins_en_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sample and gated control registers
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_sample_o <= `SMMPI_FLAG_RST;
			irq_prev_r   <= `SMMPI_PIN_IDLE;
		end else begin
			irq_sample_o <= irq_sample_nxt;
			irq_prev_r   <= sys_mgmt_irq_n_i;
		end
	end

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			code_access_eff_o <= `SMMPI_FLAG_RST;
			main_mem_eff_o    <= `SMMPI_FLAG_RST;
		end else begin
			code_access_eff_o <= code_eff_nxt;
			main_mem_eff_o    <= main_mem_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin registers
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sys_mgmt_irq_n_o      <= `SMMPI_PIN_IDLE;
			sys_mgmt_irq_n_oe_n_o <= `SMMPI_PIN_IDLE;
			smm_addr_strobe_n_o   <= `SMMPI_PIN_IDLE;
			smm_active_n_o        <= `SMMPI_PIN_IDLE;
		end else begin
			sys_mgmt_irq_n_o      <= irq_n_nxt;
			sys_mgmt_irq_n_oe_n_o <= irq_oe_n_nxt;
			smm_addr_strobe_n_o   <= strobe_n_nxt;
			smm_active_n_o        <= active_n_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event registers
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			smi_req_o <= `SMMPI_FLAG_RST;
			io_trap_o <= `SMMPI_FLAG_RST;
		end else begin
			smi_req_o <= smi_req_nxt;
			io_trap_o <= io_trap_nxt;
		end
	end

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			asrt_cnt_r <= `SMMPI_CNT_RST;
		end else begin
			asrt_cnt_r <= asrt_cnt_nxt;
		end
	end

endmodule

// [dv/smmpi_properties.sv]
// assertions on the smm pin interface ports
`timescale 1ns/1ps
module smmpi_properties (input wire clk_i, reset_i, in_smi_routine_i, smm_cycle_i,
	sys_mgmt_irq_n_i, sys_mgmt_irq_n_oe_n_o, smm_addr_strobe_n_o, smm_active_n_o, smi_req_o,
	smm_iface_select_o, smm_cfg_lock_o, pins_en_o, code_access_eff_o, main_mem_eff_o, io_trap_o);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire s = smm_iface_select_o, e = pins_en_o, q = sys_mgmt_irq_n_i;
	a_ctl_off: assert property (s && $past(s) |-> !code_access_eff_o && !main_mem_eff_o)
		else $error("ctl on");
	a_act_track: assert property (s && e |=> smm_active_n_o == !$past(in_smi_routine_i))
		else $error("act");
	a_stb_track: assert property (!s && e |=> smm_addr_strobe_n_o == !$past(smm_cycle_i))
		else $error("stb");
	a_no_drive: assert property (s && $past(s) |-> sys_mgmt_irq_n_oe_n_o)
		else $error("drv");
	a_req_fall: assert property (s && e && $fell(q) |-> ##[1:2] smi_req_o)
		else $error("req");
	a_trap_cause: assert property (io_trap_o |-> !$past(q, 2) && !$past(q, 4))
		else $error("trap");
	a_lock_hold: assert property (smm_cfg_lock_o |=> smm_cfg_lock_o && $stable(s))
		else $error("lock");
	a_idle_off: assert property (!e && !$past(e) |-> smm_addr_strobe_n_o && smm_active_n_o
		&& sys_mgmt_irq_n_oe_n_o) else $error("pins on");
endmodule
bind smmpi_top smmpi_properties smmpi_properties_inst (.*);

// [dv/smmpi_chipset.sv]
// chipset model: raises the interrupt, then answers ready
`timescale 1ns/1ps
module smmpi_chipset (input wire clk_i, input wire req_i, output reg irq_n_o = 1'h1,
	output reg ready_n_o = 1'h1);
	reg [2:0] cnt_r = 3'h0;
	always @(posedge clk_i) begin
		{irq_n_o, ready_n_o} <= {!req_i, cnt_r != 3'h4};
		cnt_r <= req_i ? cnt_r + (cnt_r != 3'h7) : 3'h0;
	end
endmodule

// [dv/test_smmpi_top.sv]
// self-checking bench for the smm pin interface
`timescale 1ns/1ps
module test_smmpi_top;
	reg clk_i = 0, reset_i = 1, cfg3_wr_i = 0, cfg_lock_wr_i = 0, pins_en_wr_i = 0, req = 0;
	reg cfg_lock_wdata_i = 0, pins_en_wdata_i = 0, smm_code_access_ctl_i = 1, io_cycle_i = 0;
	reg main_mem_access_ctl_i = 1, in_smi_routine_i = 1, smm_cycle_i = 1;
	reg [7:0] cfg3_wdata_i = 8'h00;
	reg soft_entry_i = 0, burst_ready_n_i = 1;
	wire sys_mgmt_irq_n_o, sys_mgmt_irq_n_oe_n_o, smm_addr_strobe_n_o, smm_active_n_o, ready_n_i;
	wire smm_iface_select_o, smm_cfg_lock_o, pins_en_o, code_access_eff_o, main_mem_eff_o, cs_n;
	wire smi_req_o, io_trap_o, irq_sample_o;
	wire sys_mgmt_irq_n_i = cs_n & (sys_mgmt_irq_n_oe_n_o | sys_mgmt_irq_n_o);
	wire [5:0] v = {smm_iface_select_o, smm_cfg_lock_o, pins_en_o, sys_mgmt_irq_n_oe_n_o,
		smm_active_n_o, code_access_eff_o};
	wire [5:0] u = {smm_addr_strobe_n_o, sys_mgmt_irq_n_o, main_mem_eff_o, irq_sample_o,
		smm_active_n_o, sys_mgmt_irq_n_oe_n_o};
	integer n_errors = 0, checks_done = 0, cyc = 0, i, np;
	smmpi_top smmpi_top_inst (.*);
	smmpi_chipset smmpi_chipset_inst (.clk_i(clk_i), .req_i(req), .irq_n_o(cs_n),
		.ready_n_o(ready_n_i));
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) if (++cyc == 400) begin n_errors++; give_verdict; end
	task chk(input [5:0] got, input [5:0] exp); begin
		checks_done++;
		if (got !== exp) begin n_errors++; $display("unexpected flags exp %h got %h", exp, got); end
	end endtask
	task wr(input [2:0] k, input d); begin
		@(negedge clk_i) {cfg3_wr_i, cfg_lock_wr_i, pins_en_wr_i} = k;
		{cfg3_wdata_i, cfg_lock_wdata_i, pins_en_wdata_i} = {4'h0, d, 3'h0, d, d};
		repeat (2) @(negedge clk_i) {cfg3_wr_i, cfg_lock_wr_i, pins_en_wr_i} = 3'h0;
	end endtask
	task give_verdict; begin
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	end endtask
	initial begin
		repeat (8) @(negedge clk_i);
		reset_i = 0;
		repeat (2) @(negedge clk_i) begin chk(v, 6'h07); chk(u, 6'h3b); end
		wr(3'h1, 1);
		chk(v, 6'h0b);
		chk(u, 6'h0a);
		@(negedge clk_i) chk({smi_req_o, irq_sample_o}, 6'h03);
		{in_smi_routine_i, smm_cycle_i, soft_entry_i} = 3'h1;
		@(negedge clk_i) chk(u, 6'h2e);
		soft_entry_i = 0;
		@(negedge clk_i) chk(u, 6'h2f);
		@(negedge clk_i) chk(u, 6'h2b);
		in_smi_routine_i = 1;
		wr(3'h4, 1);
		smm_cycle_i = 0;
		wr(3'h2, 1);
		wr(3'h4, 0);
		wr(3'h2, 0);
		chk(v, 6'h3c);
		in_smi_routine_i = 0;
		@(negedge clk_i) chk(u, 6'h33);
		{io_cycle_i, req, in_smi_routine_i} = 3'h7;
		np = 0;
		for (i = 0; i < 12; i++) @(negedge clk_i) np = np + smi_req_o + 4 * io_trap_o;
		chk(np, 6'h05);
		burst_ready_n_i = 0;
		@(negedge clk_i) chk(io_trap_o, 6'h01);
		burst_ready_n_i = 1;
		{io_cycle_i, req, reset_i} = 3'h1;
		@(negedge clk_i) reset_i = 0;
		repeat (2) @(negedge clk_i) begin chk(v, 6'h07); chk(u, 6'h3b); end
		wr(3'h4, 1);
		chk(v, 6'h26);
		give_verdict;
	end
endmodule
